//--- bswo_regs.svh
// register offsets, field positions, reset values and timing counts for the changeover block
`ifndef BSWO_REGS_SVH
`define BSWO_REGS_SVH
`define BSWO_DEV_ADDR      7'h2A
`define BSWO_OSC_OFS       8'h25
`define BSWO_BSW_OFS       8'h26
`define BSWO_IENA_OFS      8'h29
`define BSWO_IENB_OFS      8'h2A
`define BSWO_FLAG_OFS      8'h2B
`define BSWO_OSC_RST       8'h00
`define BSWO_BSW_RST       8'h00
`define BSWO_IEN_RST       8'h00
`define BSWO_OSC_MASK      8'h1F
`define BSWO_BSW_MASK      8'h1E
`define BSWO_IEN_MASK      8'h82
`define BSWO_JIT_BIT       4
`define BSWO_DRV_HI        3
`define BSWO_DRV_LO        2
`define BSWO_CAP_HI        1
`define BSWO_CAP_LO        0
`define BSWO_OFF_BIT       4
`define BSWO_RR_BIT        3
`define BSWO_MODE_HI       2
`define BSWO_MODE_LO       1
`define BSWO_LVL_BIT       7
`define BSWO_IEN_BIT       1
`define BSWO_FLAG_BIT      3
`define BSWO_CLK_HZ        200_000_000
`define BSWO_TICK_HZ       128
`define BSWO_PULSE_CYC     (`BSWO_CLK_HZ / `BSWO_TICK_HZ)
`endif

//--- bswo_pkg.sv
// types shared by the changeover block
package bswo_pkg;
	typedef enum logic [1:0] {
		BSWO_DRV_NORMAL = 2'h0,
		BSWO_DRV_LOW    = 2'h1,
		BSWO_DRV_HIGH   = 2'h2
	} bswo_drive_t;
	typedef enum logic [1:0] {
		BSWO_CAP_7P0  = 2'h0,
		BSWO_CAP_6P0  = 2'h1,
		BSWO_CAP_12P5 = 2'h2
	} bswo_cap_t;
	typedef enum logic [1:0] {
		BSWO_CMP_TH    = 2'h0,
		BSWO_CMP_BAT   = 2'h1,
		BSWO_CMP_HIGH  = 2'h2,
		BSWO_CMP_LOW   = 2'h3
	} bswo_cmp_t;
	// gray codes along idle, receive, ack, transmit, master ack
	typedef enum logic [2:0] {
		BSWO_ST_IDLE = 3'h0,
		BSWO_ST_RX   = 3'h1,
		BSWO_ST_ACK  = 3'h3,
		BSWO_ST_TX   = 3'h2,
		BSWO_ST_RACK = 3'h6
	} bswo_state_t;
endpackage

//--- bswo_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
module bswo_sync
(
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic rst_val,
	input  wire logic din,
	output logic      dout
);
	logic meta_r; // first stage, read only by the second stage
	logic hold_r; // second stage, kept relative to the idle level

	// both stages store the line xor its idle level, so a constant zero reset
	// still shows the idle level at dout and no false edge follows reset
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			meta_r <= 1'b0;
			hold_r <= 1'b0;
		end
		else
		begin
			meta_r <= din ^ rst_val;
			hold_r <= meta_r;
		end
	end

	// undo the idle-level offset; only a constant input meets the flop here
	assign dout = hold_r ^ rst_val;
endmodule // bswo_sync

//--- bswo_core.sv
// battery changeover and oscillator configuration with i2c register access
`timescale 1ns/1ps
`include "bswo_regs.svh"
// Overview of operation
// RL1 - osc bit 4 selects reduced clock jitter
// RL2 - osc bits 3:2 decode drive strength
// RL3 - osc bits 1:0 decode load capacitance
// RL4 - flag set on every change to battery
// RL5 - flag read only while on main supply
// RL6 - pulse or level irq on supply changes
// RL7 - serial bus pins ignored on battery
// RL8 - clock output pin hi-z on battery
// RL9 - timestamp output hi-z on battery
// RL10 - timestamp digital input ignored on battery
// RL11 - mechanical switch input always active
// RL12 - first irq pin active, clock function off
// RL13 - changeover bit 4 disables whole changeover
// RL14 - software leaves refresh rate bit zero
// RL15 - bits 2:1 select compare mode
// RL16 - supply chosen automatically from compare level
// RL17 - flag stays set until software clears
// RL18 - each pin gated by its enable bit
// RL19 - second irq pin active only on main
// RL20 - changeover bits 7:5 read zero
// RL21 - comparator results synchronised before use
module bswo_core
#(
	parameter int unsigned PULSE_CYC = `BSWO_PULSE_CYC // irq pulse length, 128 Hz period
)
(
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe,
	input  wire logic                  vdd_above_th,
	input  wire logic                  vdd_above_bat,
	output logic                       on_battery,
	input  wire logic                  clk_out_src,
	output logic                       clk_pin_out,
	output logic                       clk_pin_oe,
	input  wire logic                  ts_out_req,
	input  wire logic                  ts_out_val,
	output logic                       ts_pin_out,
	output logic                       ts_pin_oe,
	input  wire logic                  ts_pin_in,
	output logic                       ts_digital_in,
	output logic                       ts_mech_in,
	input  wire logic                  first_interrupt_pin_clk_mode,
	output logic                       first_interrupt_pin_n,
	output logic                       second_interrupt_pin_n,
	output logic                       second_interrupt_pin_oe,
	output logic                       jitter_reduce_select,
	output bswo_pkg::bswo_drive_t      crystal_drive_strength,
	output bswo_pkg::bswo_cap_t        load_cap_select,
	output logic                       changeover_refresh_rate,
	output bswo_pkg::bswo_cmp_t        changeover_compare_mode,
	output logic                       changeover_disable
);
	import bswo_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic scl_s;      // bus clock, synchronised
	logic sda_s;      // bus data, synchronised
	logic above_th_s; // main above threshold
	logic above_bat_s;// main above battery
	logic ts_s;       // timestamp pin

	// scl and sda idle high, so they reset to one
	bswo_sync u_sync_scl (.clk_sys(clk_sys), .reset(reset), .rst_val(1'b1),
		.din(scl_in), .dout(scl_s));
	bswo_sync u_sync_sda (.clk_sys(clk_sys), .reset(reset), .rst_val(1'b1),
		.din(sda_in), .dout(sda_s));
	// comparators reset to main good, so leaving reset is no changeover
	bswo_sync u_sync_th  (.clk_sys(clk_sys), .reset(reset), .rst_val(1'b1),
		.din(vdd_above_th), .dout(above_th_s)); // [RL21]
	bswo_sync u_sync_bat (.clk_sys(clk_sys), .reset(reset), .rst_val(1'b1),
		.din(vdd_above_bat), .dout(above_bat_s)); // [RL21]
	bswo_sync u_sync_ts  (.clk_sys(clk_sys), .reset(reset), .rst_val(1'b0),
		.din(ts_pin_in), .dout(ts_s));

	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] osc_r;   // oscillator_control
	logic [7:0] bsw_r;   // battery_switch_control
	logic [7:0] iena_r;  // first pin enables
	logic [7:0] ienb_r;  // second pin enables
	logic       flag_r;  // supply_changeover_flag
	logic       wr_stb;  // one-cycle register write
	logic [7:0] wr_ptr;  // write target
	logic [7:0] wr_dat;  // write data
	logic [7:0] rd_dat;  // read mux
	logic [7:0] ptr_r;   // register pointer

	////////////////////////////////////////////////////////////////////////////////
	// supply selection
	logic main_ok;      // main supply above selected level
	logic on_batt_r;    // running from backup
	logic on_batt_d_r;  // previous value for edge detect
	logic to_batt;      // change to battery
	logic any_change;   // change either way

	// compare level choice; higher level needs both, lower needs either
	always_comb
	begin
		case (changeover_compare_mode) // [RL15]
			BSWO_CMP_TH:   main_ok = above_th_s;
			BSWO_CMP_BAT:  main_ok = above_bat_s;
			BSWO_CMP_HIGH: main_ok = above_th_s & above_bat_s;
			BSWO_CMP_LOW:  main_ok = above_th_s | above_bat_s;
			default:       main_ok = above_th_s;
		endcase
	end

	// automatic switch; disabled changeover pins power to main
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			on_batt_r   <= 1'b0;
			on_batt_d_r <= 1'b0;
		end
		else
		begin
			on_batt_r   <= ~changeover_disable & ~main_ok; // [RL13] [RL16]
			on_batt_d_r <= on_batt_r;
		end
	end

	assign to_batt    = on_batt_r & ~on_batt_d_r;
	assign any_change = on_batt_r ^ on_batt_d_r;
	assign on_battery = on_batt_r;

	////////////////////////////////////////////////////////////////////////////////
	// i2c slave; bus seen idle while on battery
	logic        scl_d_r;  // previous scl
	logic        sda_d_r;  // previous sda
	logic        scl_g;    // gated scl
	logic        sda_g;    // gated sda
	logic        scl_rise; // bit sample point
	logic        scl_fall; // bit change point
	logic        bus_start;
	logic        bus_stop;
	bswo_state_t st_r;     // slave state
	logic [7:0]  sh_r;     // shift register
	logic [3:0]  bit_r;    // bits in current byte
	logic [1:0]  byte_r;   // 0 address, 1 pointer, 2 data
	logic        rd_r;     // read transfer
	logic        mack_r;   // master acked last byte

	assign scl_g     = scl_s | on_batt_r; // [RL7]
	assign sda_g     = sda_s | on_batt_r; // [RL7]
	assign scl_rise  = scl_g & ~scl_d_r;
	assign scl_fall  = ~scl_g & scl_d_r;
	assign bus_start = scl_g & scl_d_r & sda_d_r & ~sda_g;
	assign bus_stop  = scl_g & scl_d_r & ~sda_d_r & sda_g;

	// line history for edge detection
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_d_r <= scl_g;
			sda_d_r <= sda_g;
		end
	end

	// byte framing, ack and pointer handling
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			st_r   <= BSWO_ST_IDLE;
			sh_r   <= 8'h00;
			bit_r  <= 4'h0;
			byte_r <= 2'h0;
			rd_r   <= 1'b0;
			mack_r <= 1'b0;
			ptr_r  <= 8'h00;
		end
		else if (on_batt_r)
			st_r <= BSWO_ST_IDLE; // [RL7]
		else if (bus_start)
		begin
			st_r   <= BSWO_ST_RX;
			bit_r  <= 4'h0;
			byte_r <= 2'h0;
		end
		else if (bus_stop)
			st_r <= BSWO_ST_IDLE;
		else
		begin
			case (st_r)
				BSWO_ST_RX:
				begin
					if (scl_rise)
					begin
						sh_r  <= {sh_r[6:0], sda_g};
						bit_r <= bit_r + 4'h1;
					end
					else if (scl_fall && bit_r == 4'h8)
					begin
						bit_r <= 4'h0;
						if (byte_r == 2'h0)
						begin
							// foreign address: drop out until next start
							rd_r <= sh_r[0];
							st_r <= (sh_r[7:1] == `BSWO_DEV_ADDR) ? BSWO_ST_ACK
								: BSWO_ST_IDLE;
							byte_r <= 2'h1;
						end
						else if (byte_r == 2'h1)
						begin
							ptr_r  <= sh_r;
							byte_r <= 2'h2;
							st_r   <= BSWO_ST_ACK;
						end
						else
						begin
							ptr_r <= ptr_r + 8'h01;
							st_r  <= BSWO_ST_ACK;
						end
					end
				end
				BSWO_ST_ACK:
				begin
					if (scl_fall && rd_r)
					begin
						sh_r  <= rd_dat;
						ptr_r <= ptr_r + 8'h01;
						bit_r <= 4'h0;
						st_r  <= BSWO_ST_TX;
					end
					else if (scl_fall)
						st_r <= BSWO_ST_RX;
				end
				BSWO_ST_TX:
				begin
					if (scl_rise)
						bit_r <= bit_r + 4'h1;
					else if (scl_fall && bit_r == 4'h8)
						st_r <= BSWO_ST_RACK;
					else if (scl_fall)
						sh_r <= {sh_r[6:0], 1'b0};
				end
				BSWO_ST_RACK:
				begin
					if (scl_rise)
						mack_r <= ~sda_g;
					else if (scl_fall && mack_r)
					begin
						sh_r  <= rd_dat;
						ptr_r <= ptr_r + 8'h01;
						bit_r <= 4'h0;
						st_r  <= BSWO_ST_TX;
					end
					else if (scl_fall)
						st_r <= BSWO_ST_IDLE; // nack ends the read
				end
				default: st_r <= BSWO_ST_IDLE;
			endcase
		end
	end

	// write fires as the data byte is acked
	assign wr_stb = ~on_batt_r & (st_r == BSWO_ST_RX) & scl_fall & (bit_r == 4'h8)
		& (byte_r == 2'h2);
	assign wr_dat = sh_r;
	assign wr_ptr = ptr_r;

	// open-drain data line: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe  = ~on_batt_r & ((st_r == BSWO_ST_ACK)
		| ((st_r == BSWO_ST_TX) & ~sh_r[7]));

	////////////////////////////////////////////////////////////////////////////////
	// register file
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			osc_r  <= `BSWO_OSC_RST;
			bsw_r  <= `BSWO_BSW_RST;
			iena_r <= `BSWO_IEN_RST;
			ienb_r <= `BSWO_IEN_RST;
		end
		else if (wr_stb)
		begin
			case (wr_ptr)
				`BSWO_OSC_OFS:  osc_r  <= wr_dat & `BSWO_OSC_MASK;
				`BSWO_BSW_OFS:  bsw_r  <= wr_dat & `BSWO_BSW_MASK; // [RL20]
				`BSWO_IENA_OFS: iena_r <= wr_dat & `BSWO_IEN_MASK;
				`BSWO_IENB_OFS: ienb_r <= wr_dat & `BSWO_IEN_MASK;
				default:        osc_r  <= osc_r; // unmapped writes dropped
			endcase
		end
	end

	// flag: new changeover wins over a clearing write in the same cycle
	logic flag_clr; // software writes zero to the flag bit
	assign flag_clr = wr_stb & (wr_ptr == `BSWO_FLAG_OFS) & ~wr_dat[`BSWO_FLAG_BIT];

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			flag_r <= 1'b0;
		else if (to_batt)
			flag_r <= 1'b1; // [RL4]
		else if (flag_clr)
			flag_r <= 1'b0; // [RL17]
	end

	// read mux; bus is dead on battery so the flag is only seen on main
	always_comb
	begin
		rd_dat = 8'h00;
		case (ptr_r)
			`BSWO_OSC_OFS:  rd_dat = osc_r;
			`BSWO_BSW_OFS:  rd_dat = bsw_r; // [RL20]
			`BSWO_IENA_OFS: rd_dat = iena_r;
			`BSWO_IENB_OFS: rd_dat = ienb_r;
			`BSWO_FLAG_OFS: rd_dat[`BSWO_FLAG_BIT] = flag_r; // [RL5]
			default:        rd_dat = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// decoded configuration outputs, registered
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			jitter_reduce_select    <= 1'b0;
			crystal_drive_strength  <= BSWO_DRV_NORMAL;
			load_cap_select         <= BSWO_CAP_7P0;
			changeover_disable      <= 1'b0;
			changeover_refresh_rate <= 1'b0;
			changeover_compare_mode <= BSWO_CMP_TH;
		end
		else
		begin
			jitter_reduce_select <= osc_r[`BSWO_JIT_BIT]; // [RL1]
			case (osc_r[`BSWO_DRV_HI:`BSWO_DRV_LO]) // [RL2]
				2'h0:    crystal_drive_strength <= BSWO_DRV_NORMAL;
				2'h1:    crystal_drive_strength <= BSWO_DRV_LOW;
				default: crystal_drive_strength <= BSWO_DRV_HIGH;
			endcase
			case (osc_r[`BSWO_CAP_HI:`BSWO_CAP_LO]) // [RL3]
				2'h0:    load_cap_select <= BSWO_CAP_7P0;
				2'h1:    load_cap_select <= BSWO_CAP_6P0;
				default: load_cap_select <= BSWO_CAP_12P5;
			endcase
			changeover_disable      <= bsw_r[`BSWO_OFF_BIT]; // [RL13]
			// stored as written; only meaningful at zero [RL14]
			changeover_refresh_rate <= bsw_r[`BSWO_RR_BIT];
			changeover_compare_mode <= bswo_cmp_t'(bsw_r[`BSWO_MODE_HI:`BSWO_MODE_LO]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt pulse; cut short when the flag is cleared
	logic [31:0] pulse_cnt_r; // remaining pulse cycles
	logic        pulse_act;   // pulse in progress
	logic        int_a;       // first pin asserted
	logic        int_b;       // second pin asserted

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			pulse_cnt_r <= 32'h0000_0000;
		else if (any_change)
			pulse_cnt_r <= 32'(PULSE_CYC); // [RL6]
		else if (flag_clr)
			pulse_cnt_r <= 32'h0000_0000;
		else if (pulse_act)
			pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
	end

	assign pulse_act = (pulse_cnt_r != 32'h0000_0000);

	// level mode follows the flag, pulse mode follows the timer
	assign int_a = iena_r[`BSWO_IEN_BIT] // [RL18]
		& (iena_r[`BSWO_LVL_BIT] ? flag_r : pulse_act); // [RL6]
	assign int_b = ienb_r[`BSWO_IEN_BIT] // [RL18]
		& (ienb_r[`BSWO_LVL_BIT] ? flag_r : pulse_act);

	////////////////////////////////////////////////////////////////////////////////
	// pin gating, all registered
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			clk_pin_out             <= 1'b0;
			clk_pin_oe              <= 1'b0;
			ts_pin_out              <= 1'b0;
			ts_pin_oe               <= 1'b0;
			ts_digital_in           <= 1'b0;
			ts_mech_in              <= 1'b0;
			first_interrupt_pin_n   <= 1'b1;
			second_interrupt_pin_n  <= 1'b1;
			second_interrupt_pin_oe <= 1'b0;
		end
		else
		begin
			clk_pin_out   <= clk_out_src & ~on_batt_r;
			clk_pin_oe    <= ~on_batt_r; // [RL8]
			ts_pin_out    <= ts_out_val & ~on_batt_r;
			ts_pin_oe     <= ts_out_req & ~on_batt_r; // [RL9]
			ts_digital_in <= ts_s & ~on_batt_r; // [RL10]
			ts_mech_in    <= ts_s; // [RL11]
			// clock mode on the first pin only while on main
			if (first_interrupt_pin_clk_mode && !on_batt_r)
				first_interrupt_pin_n <= clk_out_src;
			else
				first_interrupt_pin_n <= ~int_a; // [RL12]
			second_interrupt_pin_n  <= ~(int_b & ~on_batt_r);
			second_interrupt_pin_oe <= ~on_batt_r; // [RL19]
		end
	end
endmodule // bswo_core

//--- bswo_props.sv
// checker for supply changeover selection and pin gating on battery
`timescale 1ns/1ps
module bswo_props
(
	input wire logic             clk_sys,
	input wire logic             reset,
	input wire logic             vdd_above_th,
	input wire logic             vdd_above_bat,
	input wire logic             on_battery,
	input wire logic             clk_pin_oe,
	input wire logic             ts_pin_oe,
	input wire logic             ts_pin_in,
	input wire logic             ts_digital_in,
	input wire logic             ts_mech_in,
	input wire logic             sda_oe,
	input wire logic             first_interrupt_pin_n,
	input wire logic             second_interrupt_pin_n,
	input wire logic             second_interrupt_pin_oe,
	input bswo_pkg::bswo_cmp_t   changeover_compare_mode,
	input wire logic             changeover_disable
);
	import bswo_pkg::*;
	logic want_bat; // supply level the selected mode asks for
	// comparator view per mode; windows below are long enough to cover sync latency
	always_comb
	begin
		case (changeover_compare_mode)
			BSWO_CMP_TH:   want_bat = !vdd_above_th;
			BSWO_CMP_BAT:  want_bat = !vdd_above_bat;
			BSWO_CMP_HIGH: want_bat = !(vdd_above_th && vdd_above_bat);
			default:       want_bat = !(vdd_above_th || vdd_above_bat);
		endcase
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_auto_to_battery: assert property
		((want_bat && !changeover_disable)[*5] |-> on_battery)
		else $error("supply not switched to battery");
	a_auto_to_main: assert property
		((!want_bat || changeover_disable)[*5] |-> !on_battery)
		else $error("supply not kept on main");
	a_batt_clk_hiz: assert property (on_battery |=> !clk_pin_oe)
		else $error("clock pin driven on battery");
	a_batt_ts_hiz: assert property (on_battery |=> !ts_pin_oe)
		else $error("timestamp pin driven on battery");
	a_batt_ts_ignored: assert property (on_battery |=> !ts_digital_in)
		else $error("timestamp input passed on battery");
	a_batt_bus_off: assert property (on_battery |=> !sda_oe)
		else $error("data line driven on battery");
	a_batt_second_off: assert property
		(on_battery |=> second_interrupt_pin_n && !second_interrupt_pin_oe)
		else $error("second irq pin active on battery");
	a_mech_follows: assert property ($stable(ts_pin_in)[*5] |-> ts_mech_in == ts_pin_in)
		else $error("switch detector input not passed");
	c_to_battery: cover property ($rose(on_battery));
	c_to_main: cover property ($fell(on_battery));
	c_first_irq: cover property ($fell(first_interrupt_pin_n));
endmodule // bswo_props

bind bswo_core bswo_props bswo_props_inst
(
	.clk_sys, .reset, .vdd_above_th, .vdd_above_bat, .on_battery, .clk_pin_oe, .ts_pin_oe,
	.ts_pin_in, .ts_digital_in, .ts_mech_in, .sda_oe, .first_interrupt_pin_n,
	.second_interrupt_pin_n, .second_interrupt_pin_oe, .changeover_compare_mode,
	.changeover_disable
);

//--- bswo_host.sv
// i2c host model that programs the changeover block registers
`timescale 1ns/1ps
`include "bswo_regs.svh"
module bswo_host
(
	input  wire logic clk_sys,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// bus idle: both lines released high
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// half scl period, twice the minimum phase
	task automatic ph();
		repeat (8) @(negedge clk_sys);
	endtask
	// gap after scl falls so data never moves in the same sync cycle
	task automatic gap();
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic start();
		gap();
		sda_low = 1'b0;
		ph();
		scl = 1'b1;
		ph();
		sda_low = 1'b1;
		ph();
		scl = 1'b0;
	endtask
	task automatic stop();
		gap();
		sda_low = 1'b1;
		ph();
		scl = 1'b1;
		ph();
		sda_low = 1'b0;
		ph();
	endtask
	// eight bits msb first plus the ack slot; sampled at the end of scl high
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
		logic [8:0] w;
		logic [8:0] r;
		w = {d, ai};
		for (int i = 8; i >= 0; i--)
		begin
			gap();
			sda_low = !w[i];
			ph();
			scl = 1'b1;
			ph();
			r[i] = sda;
			scl = 1'b0;
		end
		q = r[8:1];
		ao = r[0];
	endtask
	// nak high when any byte went unacknowledged
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d, output logic nak);
		logic [7:0] x;
		logic [2:0] a;
		start();
		xfer({`BSWO_DEV_ADDR, 1'b0}, 1'b1, x, a[2]);
		xfer(ofs, 1'b1, x, a[1]);
		xfer(d, 1'b1, x, a[0]);
		stop();
		nak = |a;
	endtask
	task automatic rd(input logic [7:0] ofs, output logic [7:0] q, output logic nak);
		logic [7:0] x;
		logic [2:0] a;
		logic       e;
		start();
		xfer({`BSWO_DEV_ADDR, 1'b0}, 1'b1, x, a[2]);
		xfer(ofs, 1'b1, x, a[1]);
		start();
		xfer({`BSWO_DEV_ADDR, 1'b1}, 1'b1, x, a[0]);
		xfer(8'hFF, 1'b1, q, e);
		stop();
		nak = |a;
	endtask
endmodule // bswo_host

//--- bswo_core_tb.sv
// testbench: register programming, supply changeover, irq and pin gating
`timescale 1ns/1ps
`include "bswo_regs.svh"
module bswo_core_tb;
	import bswo_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        vdd_above_th = 1'b1;
	logic        vdd_above_bat = 1'b1;
	logic        ts_pin_in = 1'b0;
	logic        scl, host_low, sda_out, sda_oe, on_battery, clk_pin_oe, ts_pin_oe;
	logic        ts_digital_in, ts_mech_in, first_interrupt_pin_n, second_interrupt_pin_n;
	logic        second_interrupt_pin_oe, jitter_reduce_select, changeover_refresh_rate;
	logic        changeover_disable, a, clk_pin_out, ts_pin_out;
	logic        first_interrupt_pin_clk_mode = 1'b0;
	logic [7:0]  q;
	bswo_drive_t crystal_drive_strength;
	bswo_cap_t   load_cap_select;
	bswo_cmp_t   changeover_compare_mode;
	int          fails = 0;
	int          comparisons = 0;
	// open drain data line with pull-up
	wire sda = (sda_oe ? sda_out : 1'b1) && !host_low;
	always #2.5 clk_sys = !clk_sys;
	bswo_core #(.PULSE_CYC(16)) bswo_core_inst
	(
		.clk_sys, .reset, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .vdd_above_th,
		.vdd_above_bat, .on_battery, .clk_out_src(1'b1), .clk_pin_out, .clk_pin_oe,
		.ts_out_req(1'b1), .ts_out_val(1'b1), .ts_pin_out, .ts_pin_oe, .ts_pin_in,
		.ts_digital_in, .ts_mech_in, .first_interrupt_pin_clk_mode, .first_interrupt_pin_n,
		.second_interrupt_pin_n, .second_interrupt_pin_oe, .jitter_reduce_select,
		.crystal_drive_strength, .load_cap_select, .changeover_refresh_rate,
		.changeover_compare_mode, .changeover_disable
	);
	bswo_host bswo_host_inst (.clk_sys, .sda, .scl, .sda_low(host_low));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// two-bit code where both upper codes mean the top setting
	function automatic logic [7:0] dec(input logic [1:0] c);
		return c[1] ? 8'h02 : {6'h00, c};
	endfunction
	// battery wanted for mode m, c = {above threshold, above battery}
	function automatic logic want(input logic [1:0] m, input logic [1:0] c);
		return m == 2'h0 ? !c[1] : m == 2'h1 ? !c[0] : m == 2'h2 ? !(&c) : !(|c);
	endfunction
	task automatic settle();
		repeat (8) @(negedge clk_sys);
	endtask
	// hang guard, well past the expected run length
	initial
	begin
		repeat (90000) @(posedge clk_sys);
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		test_done();
	end
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(negedge clk_sys);
		reset = 1'b0;
		settle();
		bswo_host_inst.rd(`BSWO_BSW_OFS, q, a);
		chk(q, `BSWO_BSW_RST);
		bswo_host_inst.rd(`BSWO_OSC_OFS, q, a);
		chk(q, `BSWO_OSC_RST);
		for (int i = 0; i < 32; i++)
		begin
			bswo_host_inst.wr(`BSWO_OSC_OFS, i[7:0], a);
			chk(a, 1'b0);
			chk(jitter_reduce_select, i[4]);
			chk(crystal_drive_strength, dec(i[3:2]));
			chk(load_cap_select, dec(i[1:0]));
			bswo_host_inst.rd(`BSWO_OSC_OFS, q, a);
			chk(q, i[7:0]);
		end
		bswo_host_inst.wr(`BSWO_BSW_OFS, 8'hFF, a);
		bswo_host_inst.rd(`BSWO_BSW_OFS, q, a);
		chk(q, 8'h1E);
		chk({changeover_disable, changeover_refresh_rate}, 8'h03);
		vdd_above_th = 1'b0;
		vdd_above_bat = 1'b0;
		settle();
		chk(on_battery, 1'b0);
		for (int m = 0; m < 4; m++)
		begin
			vdd_above_th = 1'b1;
			vdd_above_bat = 1'b1;
			settle();
			bswo_host_inst.wr(`BSWO_BSW_OFS, {5'h00, m[1:0], 1'b0}, a);
			chk(changeover_compare_mode, m[7:0]);
			for (int c = 0; c < 4; c++)
			begin
				{vdd_above_th, vdd_above_bat} = c[1:0];
				settle();
				chk(on_battery, want(m[1:0], c[1:0]));
				chk(first_interrupt_pin_n, 1'b1);
			end
		end
		vdd_above_th = 1'b1;
		vdd_above_bat = 1'b1;
		settle();
		bswo_host_inst.wr(`BSWO_BSW_OFS, 8'h00, a);
		bswo_host_inst.rd(`BSWO_FLAG_OFS, q, a);
		chk(q & 8'h08, 8'h08);
		bswo_host_inst.wr(`BSWO_FLAG_OFS, 8'h00, a);
		bswo_host_inst.rd(`BSWO_FLAG_OFS, q, a);
		chk(q & 8'h08, 8'h00);
		bswo_host_inst.wr(`BSWO_IENA_OFS, 8'h82, a);
		bswo_host_inst.wr(`BSWO_IENB_OFS, 8'h02, a);
		chk(first_interrupt_pin_n, 1'b1);
		// enter battery: level irq on first pin, gated pins elsewhere
		vdd_above_th = 1'b0;
		ts_pin_in = 1'b1;
		first_interrupt_pin_clk_mode = 1'b1;
		settle();
		chk(first_interrupt_pin_n, 1'b0);
		chk({clk_pin_oe, ts_pin_oe, ts_digital_in}, 8'h00);
		chk({clk_pin_out, ts_pin_out}, 8'h00);
		chk(ts_mech_in, 1'b1);
		chk({second_interrupt_pin_oe, second_interrupt_pin_n}, 8'h01);
		bswo_host_inst.wr(`BSWO_OSC_OFS, 8'h00, a);
		chk(a, 1'b1);
		bswo_host_inst.rd(`BSWO_FLAG_OFS, q, a);
		chk(a, 1'b1);
		// back to main: pulse on second pin, flag still holds first pin
		vdd_above_th = 1'b1;
		first_interrupt_pin_clk_mode = 1'b0;
		repeat (7) @(negedge clk_sys);
		chk(second_interrupt_pin_n, 1'b0);
		repeat (25) @(negedge clk_sys);
		chk({second_interrupt_pin_n, first_interrupt_pin_n}, 8'h02);
		chk({clk_pin_oe, ts_pin_oe, ts_digital_in}, 8'h07);
		chk({clk_pin_out, ts_pin_out}, 8'h03);
		bswo_host_inst.rd(`BSWO_OSC_OFS, q, a);
		chk(q, 8'h1F);
		bswo_host_inst.wr(`BSWO_FLAG_OFS, 8'h00, a);
		repeat (4) @(negedge clk_sys);
		chk(first_interrupt_pin_n, 1'b1);
		bswo_host_inst.rd(8'h30, q, a);
		chk(q, 8'h00);
		test_done();
	end
endmodule // bswo_core_tb
